/* include/i2c_regs_pkg.sv */
// Purpose: constants and carriers of the i2c channel register bank
// Assumes: 32-bit classic wishbone, one register per aligned word
// Notes:   registers hold 16 bits, upper bus bits read zero
package i2c_regs_pkg;
  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [5:0] OFS_CLOCK = 6'h00;
  localparam logic [5:0] OFS_MODE  = 6'h04;
  localparam logic [5:0] OFS_BAUD  = 6'h08;
  localparam logic [5:0] OFS_OADR  = 6'h0c;
  localparam logic [5:0] OFS_CTL   = 6'h10;
  localparam logic [5:0] OFS_TXD   = 6'h14;
  localparam logic [5:0] OFS_RXD   = 6'h18;
  localparam logic [5:0] OFS_INTF  = 6'h1c;
  localparam logic [5:0] OFS_INTE  = 6'h20;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CLK_DEBUG_RUN = 8;
  localparam int CLK_DIV_LSB   = 4;
  localparam int CLK_SRC_LSB   = 0;
  localparam int MOD_ADDR_W    = 2;
  localparam int MOD_GC_EN     = 1;
  localparam int CTL_MASTER    = 5;
  localparam int CTL_NACK      = 4;
  localparam int CTL_STOP      = 3;
  localparam int CTL_START     = 2;
  localparam int CTL_SRST      = 1;
  localparam int CTL_ENABLE    = 0;
  localparam int FLAG_RX_FULL  = 1;
  localparam int FLAG_TX_EMPTY = 0;
  localparam logic [7:0] FLAG_W1C_MASK = 8'hfc;
  // ************************************************************
  // reset values and timing
  // ************************************************************
  localparam logic [6:0] BAUD_RESET  = 7'h7f;
  localparam logic [2:0] SRST_CYCLES = 3'h4;
  localparam logic [1:0] SRC_INTERNAL  = 2'h0;
  localparam logic [1:0] SRC_LOW_SPEED = 2'h1;
  localparam logic [1:0] SRC_HIGH_SPD  = 2'h2;
  localparam logic [1:0] SRC_EXTERNAL  = 2'h3;
  // ************************************************************
  // carriers to and from the bus engine
  // ************************************************************
  typedef struct packed {
    logic       byte_end;
    logic       general_call;
    logic       nack_rx;
    logic       stop_seen;
    logic       start_seen;
    logic       error;
    logic       rx_load;
    logic       tx_empty;
    logic [7:0] rx_data;
    logic       start_done;
    logic       stop_done;
    logic       nack_done;
    logic       bus_busy;
    logic       transmit_direction;
  } engine_event_t;
  typedef struct packed {
    logic       module_enable;
    logic       soft_reset;
    logic       master_select;
    logic       start_request;
    logic       stop_request;
    logic       nack_request;
    logic       address_width_select;
    logic       general_call_enable;
    logic [9:0] own_slave_address;
    logic [6:0] baud_value;
    logic [7:0] tx_data;
  } engine_ctrl_t;
endpackage

/* rtl/op_clock_gen.sv */
// Purpose: operating clock enable from source select, divider and gating
// Assumes: source ticks are one-cycle pulses on clk_i
// Notes:   output is a registered tick, not a derived clock
`timescale 1ns/1ps
module op_clock_gen #(
  parameter logic [3:0] SOURCES_PRESENT = 4'hf
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] src_tick_i,
  input  wire logic [1:0] src_sel_i,
  input  wire logic [1:0] div_sel_i,
  input  wire logic       module_enable_i,
  input  wire logic       debug_mode_i,
  input  wire logic       debug_run_i,
  output logic            tick_o
);
  // ************************************************************
  // selection and division
  // ************************************************************
  logic [2:0] div_count;
  wire        run = module_enable_i & (~debug_mode_i | debug_run_i);
  wire        src_tick = src_tick_i[src_sel_i] & SOURCES_PRESENT[src_sel_i];
  wire        divisible = (src_sel_i == i2c_regs_pkg::SRC_INTERNAL) |
                          (src_sel_i == i2c_regs_pkg::SRC_HIGH_SPD);
  wire [2:0]  div_mask = (3'h1 << div_sel_i) - 3'h1;
  wire        div_hit = ~divisible | ((div_count & div_mask) == 3'h0);
  wire [2:0]  next_div_count = div_count + 3'h1;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_count <= 3'h0;
      tick_o    <= 1'b0;
    end else begin
      if (run & src_tick) begin
        div_count <= next_div_count;
      end
      tick_o <= run & src_tick & div_hit;
    end
  end
endmodule

/* rtl/i2c_controller_register_bank.sv */
// Purpose: software register bank of one i2c controller channel
// Assumes: bus engine runs on clk_i and reports events as pulses
// Notes:   pins sda_i and scl_i are synchronised before use
//
// Contract
// - debug-run bit 8 keeps clock running in debug mode; else clock stops
// - source field picks internal, low-speed, high-speed or external clock
// - divider 1,2,4,8 for internal and high-speed; others undivided
// - slave uses 10-bit address when width bit set, else 7-bit
// - general calls answered only when general-call enable is set
// - baud value resets to 0x7f and must never be zero
// - ten address bits compared in 10-bit mode, low seven otherwise
// - master-select bit 5 chooses master (1) or slave (0)
// - nack request bit 4 set by write 1, self-clears after nack
// - stop request bit 3 master only, clears after bus free time
// - start request bit 2 master only, clears once start produced
// - soft reset bit 1 resets engine and flags, self-clears
// - enable bit 0 gates the operating clock
// - receive data read-only; reading clears receive-full flag
// - transmit-empty flag read-only; cleared by transmit data write
// - status bit 12 shows data line low, bit 11 clock line low
// - status bit 10 bus busy, bit 9 transmit direction
// - flags 7..2 set by events, cleared by writing 1
// - enable bit per flag position enables that interrupt
// - interrupt request only while an enabled flag is set
//
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
module i2c_controller_register_bank #(
  parameter logic [3:0] SOURCES_PRESENT = 4'hf
) (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic                         cyc_i,
  input  wire logic                         stb_i,
  input  wire logic                         we_i,
  input  wire logic [5:0]                   adr_i,
  input  wire logic [3:0]                   sel_i,
  input  wire logic [31:0]                  dat_i,
  output logic      [31:0]                  dat_o,
  output logic                              ack_o,
  input  wire logic                         debug_mode_i,
  input  wire logic [3:0]                   src_tick_i,
  input  wire logic                         sda_i,
  input  wire logic                         scl_i,
  input  wire i2c_regs_pkg::engine_event_t  event_i,
  output i2c_regs_pkg::engine_ctrl_t        ctrl_o,
  output logic                              op_tick_o,
  output logic                              irq_o
);
  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic {SR_IDLE, SR_RUN} srst_state_t;
  srst_state_t srst_state;
  logic [2:0]  srst_count;
  logic        debug_run;
  logic [1:0]  clock_divider;
  logic [1:0]  clock_source_select;
  logic        address_width_select;
  logic        general_call_enable;
  logic [6:0]  baud_value;
  logic [9:0]  own_slave_address;
  logic        master_select;
  logic        nack_request;
  logic        stop_request;
  logic        start_request;
  logic        module_enable;
  logic [7:0]  tx_data;
  logic [7:0]  rx_data;
  logic [7:0]  flags;
  logic [7:0]  int_enable;
  logic        bus_busy;
  logic        transmit_direction;
  logic        sda_meta;
  logic        sda_sync;
  logic        scl_meta;
  logic        scl_sync;

  // ************************************************************
  // bus decode
  // ************************************************************
  wire        req      = cyc_i & stb_i & ~ack_o;
  wire        wr       = req & we_i;
  wire        rd       = req & ~we_i;
  wire [5:0]  word_adr = {adr_i[5:2], 2'h0};
  wire [15:0] wmask    = {{8{sel_i[1]}}, {8{sel_i[0]}}};
  wire [15:0] wbits    = dat_i[15:0] & wmask;
  wire        cfg_open = ~module_enable;
  wire hit_clock = word_adr == i2c_regs_pkg::OFS_CLOCK;
  wire hit_mode  = word_adr == i2c_regs_pkg::OFS_MODE;
  wire hit_baud  = word_adr == i2c_regs_pkg::OFS_BAUD;
  wire hit_oadr  = word_adr == i2c_regs_pkg::OFS_OADR;
  wire hit_ctl   = word_adr == i2c_regs_pkg::OFS_CTL;
  wire hit_txd   = word_adr == i2c_regs_pkg::OFS_TXD;
  wire hit_rxd   = word_adr == i2c_regs_pkg::OFS_RXD;
  wire hit_intf  = word_adr == i2c_regs_pkg::OFS_INTF;
  wire hit_inte  = word_adr == i2c_regs_pkg::OFS_INTE;
  wire wr_clock  = wr & hit_clock & cfg_open;
  wire wr_mode   = wr & hit_mode & cfg_open;
  wire wr_baud   = wr & hit_baud & cfg_open & sel_i[0];
  wire wr_oadr   = wr & hit_oadr & cfg_open;
  wire wr_ctl    = wr & hit_ctl;
  wire wr_txd    = wr & hit_txd & sel_i[0];
  wire wr_intf   = wr & hit_intf;
  wire wr_inte   = wr & hit_inte;
  wire rd_rxd    = rd & hit_rxd;

  // ************************************************************
  // read words
  // ************************************************************
  wire [15:0] clock_word = {7'h00, debug_run, 2'h0, clock_divider, 2'h0, clock_source_select};
  wire [15:0] mode_word  = {13'h0000, address_width_select, general_call_enable, 1'b0};
  wire [15:0] ctl_word   = {10'h000, master_select, nack_request, stop_request,
                            start_request, srst_state == SR_RUN, module_enable};
  wire [15:0] intf_word  = {3'h0, ~sda_sync, ~scl_sync, bus_busy, transmit_direction,
                            1'b0, flags};
  wire [15:0] rd_word =
    hit_clock ? clock_word :
    hit_mode  ? mode_word :
    hit_baud  ? {9'h000, baud_value} :
    hit_oadr  ? {6'h00, own_slave_address} :
    hit_ctl   ? ctl_word :
    hit_txd   ? {8'h00, tx_data} :
    hit_rxd   ? {8'h00, rx_data} :
    hit_intf  ? intf_word :
    hit_inte  ? {8'h00, int_enable} : 16'h0000;

  // ************************************************************
  // next values
  // ************************************************************
  wire srst_run   = srst_state == SR_RUN;
  wire srst_start = wr_ctl & wbits[i2c_regs_pkg::CTL_SRST];
  wire [1:0] src_new = wbits[i2c_regs_pkg::CLK_SRC_LSB +: 2];
  wire src_ok     = SOURCES_PRESENT[src_new];
  wire [6:0] baud_new = wbits[6:0];
  wire gc_event   = event_i.general_call & general_call_enable & ~master_select;
  wire [7:0] ev_set = {event_i.byte_end, gc_event, event_i.nack_rx, event_i.stop_seen,
                       event_i.start_seen, event_i.error, event_i.rx_load,
                       event_i.tx_empty};
  wire [7:0] w1c_clr = wr_intf ? (wbits[7:0] & i2c_regs_pkg::FLAG_W1C_MASK) : 8'h00;
  wire [7:0] side_clr = {6'h00, rd_rxd, wr_txd};
  wire [7:0] next_flags = srst_run ? 8'h00 : (ev_set | (flags & ~(w1c_clr | side_clr)));
  wire set_nack  = wr_ctl & wbits[i2c_regs_pkg::CTL_NACK];
  wire set_stop  = wr_ctl & wbits[i2c_regs_pkg::CTL_STOP] & master_select;
  wire set_start = wr_ctl & wbits[i2c_regs_pkg::CTL_START] & master_select;
  wire next_nack  = ~srst_run & (set_nack | (nack_request & ~event_i.nack_done));
  wire next_stop  = ~srst_run & (set_stop | (stop_request & ~event_i.stop_done));
  wire next_start = ~srst_run & (set_start | (start_request & ~event_i.start_done));
  wire [9:0] eff_addr = address_width_select ? own_slave_address
                                             : {3'h0, own_slave_address[6:0]};
  i2c_regs_pkg::engine_ctrl_t next_ctrl;
  assign next_ctrl = '{module_enable: module_enable, soft_reset: srst_run,
                       master_select: master_select, start_request: start_request,
                       stop_request: stop_request, nack_request: nack_request,
                       address_width_select: address_width_select,
                       general_call_enable: general_call_enable,
                       own_slave_address: eff_addr, baud_value: baud_value,
                       tx_data: tx_data};
  wire [2:0] next_srst_count = srst_count - 3'h1;

  // ************************************************************
  // bus slave and pins
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      dat_o <= rd ? {16'h0000, rd_word} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
    end else begin
      sda_meta <= sda_i;
      sda_sync <= sda_meta;
      scl_meta <= scl_i;
      scl_sync <= scl_meta;
    end
  end

  // ************************************************************
  // configuration registers
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      debug_run            <= 1'b0;
      clock_divider        <= 2'h0;
      clock_source_select  <= 2'h0;
      address_width_select <= 1'b0;
      general_call_enable  <= 1'b0;
      baud_value           <= i2c_regs_pkg::BAUD_RESET;
      own_slave_address    <= 10'h000;
    end else begin
      if (wr_clock & sel_i[1]) begin
        debug_run <= wbits[i2c_regs_pkg::CLK_DEBUG_RUN];
      end
      if (wr_clock & sel_i[0]) begin
        clock_divider <= wbits[i2c_regs_pkg::CLK_DIV_LSB +: 2];
        if (src_ok) begin
          clock_source_select <= src_new;
        end
      end
      if (wr_mode & sel_i[0]) begin
        address_width_select <= wbits[i2c_regs_pkg::MOD_ADDR_W];
        general_call_enable  <= wbits[i2c_regs_pkg::MOD_GC_EN];
      end
      if (wr_baud & (baud_new != 7'h00)) begin
        baud_value <= baud_new;
      end
      if (wr_oadr & sel_i[0]) begin
        own_slave_address[7:0] <= wbits[7:0];
      end
      if (wr_oadr & sel_i[1]) begin
        own_slave_address[9:8] <= wbits[9:8];
      end
    end
  end

  // ************************************************************
  // control, data and flags
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_select <= 1'b0;
      module_enable <= 1'b0;
      nack_request  <= 1'b0;
      stop_request  <= 1'b0;
      start_request <= 1'b0;
    end else begin
      if (wr_ctl & sel_i[0]) begin
        master_select <= wbits[i2c_regs_pkg::CTL_MASTER];
        module_enable <= wbits[i2c_regs_pkg::CTL_ENABLE];
      end
      nack_request  <= next_nack;
      stop_request  <= next_stop;
      start_request <= next_start;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_data            <= 8'h00;
      rx_data            <= 8'h00;
      flags              <= 8'h00;
      int_enable         <= 8'h00;
      bus_busy           <= 1'b0;
      transmit_direction <= 1'b0;
    end else begin
      if (wr_txd) begin
        tx_data <= wbits[7:0];
      end
      if (event_i.rx_load) begin
        rx_data <= event_i.rx_data;
      end
      if (wr_inte & sel_i[0]) begin
        int_enable <= wbits[7:0];
      end
      flags              <= next_flags;
      bus_busy           <= event_i.bus_busy & ~srst_run;
      transmit_direction <= event_i.transmit_direction;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      srst_state <= SR_IDLE;
      srst_count <= 3'h0;
    end else begin
      unique case (srst_state)
        SR_IDLE: begin
          if (srst_start) begin
            srst_state <= SR_RUN;
            srst_count <= i2c_regs_pkg::SRST_CYCLES;
          end
        end
        SR_RUN: begin
          srst_count <= next_srst_count;
          if (srst_count == 3'h1) begin
            srst_state <= SR_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o  <= 1'b0;
      ctrl_o <= '0;
    end else begin
      irq_o  <= |(flags & int_enable);
      ctrl_o <= next_ctrl;
    end
  end

  // ************************************************************
  // operating clock
  // ************************************************************
  op_clock_gen #(
    .SOURCES_PRESENT (SOURCES_PRESENT)
  ) u_clock_gen (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .src_tick_i      (src_tick_i),
    .src_sel_i       (clock_source_select),
    .div_sel_i       (clock_divider),
    .module_enable_i (module_enable),
    .debug_mode_i    (debug_mode_i),
    .debug_run_i     (debug_run),
    .tick_o          (op_tick_o)
  );

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  bus_ack_a: assert property (req |=> ack_o ##1 !ack_o)
    else $error("ack not one cycle after request");
  cfg_lock_a: assert property (module_enable && wr && hit_baud |=> $stable(baud_value))
    else $error("baud changed while enabled");
  baud_nonzero_a: assert property (baud_value != 7'h00)
    else $error("baud value is zero");
  start_slave_a: assert property (!master_select && !start_request |=> !start_request)
    else $error("start request rose in slave mode");
  tbe_clear_a: assert property (wr_txd && !event_i.tx_empty && !srst_run
                                |=> !flags[i2c_regs_pkg::FLAG_TX_EMPTY])
    else $error("transmit empty not cleared by write");
  rbf_clear_a: assert property (rd_rxd && !event_i.rx_load
                                |=> !flags[i2c_regs_pkg::FLAG_RX_FULL])
    else $error("receive full not cleared by read");
  flag_w1c_a: assert property (wr_intf && wbits[2] && !event_i.error |=> !flags[2])
    else $error("error flag not cleared by write one");
  flag_set_a: assert property (event_i.byte_end && !srst_run |=> flags[7])
    else $error("byte end event lost");
  srst_len_a: assert property ($rose(srst_run) |-> srst_run [*4] ##1 !srst_run)
    else $error("soft reset length wrong");
  srst_clear_a: assert property (srst_run |=> flags == 8'h00 && !start_request
                                 && !stop_request && !nack_request)
    else $error("soft reset left state set");
  irq_a: assert property ((flags & int_enable) != 8'h00 |=> irq_o)
    else $error("enabled flag gave no interrupt");
  irq_quiet_a: assert property ((flags & int_enable) == 8'h00 |=> !irq_o)
    else $error("interrupt without enabled flag");
  addr7_a: assert property (!address_width_select |=> ctrl_o.own_slave_address[9:7] == 3'h0)
    else $error("upper address bits used in 7-bit mode");
  tick_off_a: assert property (!module_enable |=> !op_tick_o)
    else $error("operating clock ran while disabled");

  srst_c:  cover property (srst_start ##1 srst_run);
  start_c: cover property (set_start ##1 start_request ##[1:20] !start_request);
  irq_c:   cover property ($rose(irq_o));
  rxd_c:   cover property (event_i.rx_load ##[1:10] rd_rxd);
endmodule

/* tb/engine_model.sv */
// Purpose: bus engine and bus line model facing the register bank
// Assumes: event pulses last one cycle of clk_i
// Notes:   lines idle high through their pull-ups
`timescale 1ns/1ps
module engine_model (
  input  wire logic                   clk_i,
  output i2c_regs_pkg::engine_event_t event_o,
  output logic                        sda_o,
  output logic                        scl_o
);
  initial begin
    event_o = '0;
    sda_o = 1'b1;
    scl_o = 1'b1;
  end
  // one-cycle event pulse, busy and direction levels kept
  task automatic fire(input logic [20:0] e);
    @(posedge clk_i);
    event_o <= e | (event_o & 21'h3);
    @(posedge clk_i);
    event_o <= event_o & 21'h3;
  endtask
  // level change, then two edges so the pin synchroniser has settled
  task automatic lines(input logic s_d, input logic s_c, input logic [1:0] lv);
    @(posedge clk_i);
    sda_o <= s_d;
    scl_o <= s_c;
    event_o[1:0] <= lv;
    repeat (2) @(posedge clk_i);
  endtask
endmodule

/* tb/tb_top.sv */
// Purpose: self-checking bench of the i2c register bank
// Assumes: ack comes one cycle after a request is taken
// Notes:   read results are checked from a queue of notes
`timescale 1ns/1ps
module tb_top;
  logic                        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic                        debug_mode_i, sda, scl, op_tick_o, irq_o;
  logic [5:0]                  adr_i;
  logic [3:0]                  sel_i, src_tick_i;
  logic [31:0]                 dat_i, dat_o;
  logic [7:0]                  d;
  i2c_regs_pkg::engine_event_t ev;
  i2c_regs_pkg::engine_ctrl_t  ctrl;
  logic [31:0]                 exp_q[$];
  int                          n_fail, check_count, i, n;
  localparam logic [5:0]  ca [6] = '{6'h00, 6'h04, 6'h08, 6'h08, 6'h0c, 6'h20};
  localparam logic [15:0] cv [6] = '{16'hffff, 16'hffff, 16'h0, 16'h01a5, 16'hffff, 16'hffff};
  localparam logic [31:0] ce [6] = '{32'h0133, 32'h6, 32'h7f, 32'h25, 32'h3ff, 32'hff};
  i2c_controller_register_bank dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .debug_mode_i(debug_mode_i), .src_tick_i(src_tick_i), .sda_i(sda), .scl_i(scl),
    .event_i(ev), .ctrl_o(ctrl), .op_tick_o(op_tick_o), .irq_o(irq_o));
  engine_model u_eng (.clk_i(clk_i), .event_o(ev), .sda_o(sda), .scl_o(scl));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic test_done();
    n_fail += exp_q.size();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    check_count++;
    if (got !== want) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  // ****************************************
  // wishbone classic master
  // ****************************************
  task automatic wb(input logic w, input logic [5:0] a, input logic [15:0] v);
    int t;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {16'h0, v};
    sel_i <= 4'h3;
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 20);
    if (ack_o !== 1'b1) begin
      n_fail++;
      test_done();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    wb(1'b1, a, v);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] want);
    exp_q.push_back(want);
    wb(1'b0, a, 16'h0);
  endtask
  task automatic ticks(input int want);
    repeat (4) @(posedge clk_i);
    n = 0;
    repeat (64) begin
      @(posedge clk_i);
      n += int'(op_tick_o === 1'b1);
    end
    cmp(n, want);
  endtask
  // read results taken from the queue when answered
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0) cmp(dat_o, exp_q.pop_front());
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, debug_mode_i} = '0;
    rst_i = 1'b1;
    src_tick_i = 4'hf;
    n_fail = 0;
    check_count = 0;
    d = 8'($urandom(17447));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 10; i++) rd(6'(i * 4), (i == 2) ? 32'h7f : 32'h0);
    for (i = 0; i < 6; i++) begin
      wr(ca[i], cv[i]);
      rd(ca[i], ce[i]);
    end
    cmp(32'(ctrl.own_slave_address), 32'h3ff);
    wr(6'h04, 16'h0002);
    cmp(32'(ctrl.own_slave_address), 32'h07f);
    wr(6'h10, 16'h0021);
    wr(6'h08, 16'h0011);
    rd(6'h08, 32'h25);
    for (i = 2; i < 5; i++) begin
      wr(6'h10, 16'h0021 | 16'(1 << i));
      rd(6'h10, 32'h21 | 32'(1 << i));
      u_eng.fire(21'(1 << (6 - i)));
      rd(6'h10, 32'h21);
    end
    wr(6'h10, 16'h0001);
    wr(6'h10, 16'h000d);
    rd(6'h10, 32'h1);
    for (i = 2; i < 8; i++) begin
      u_eng.fire(21'(1 << (13 + i)));
      wr(6'h1c, 16'hfc & ~16'(1 << i));
      rd(6'h1c, 32'(1 << i));
      cmp(irq_o, 1'b1);
      wr(6'h1c, 16'(1 << i));
      rd(6'h1c, 32'h0);
    end
    u_eng.fire(21'h8000);
    wr(6'h20, 16'h00fb);
    cmp(irq_o, 1'b0);
    wr(6'h20, 16'h00ff);
    cmp(irq_o, 1'b1);
    wr(6'h10, 16'h0011);
    wr(6'h10, 16'h0013);
    repeat (6) @(posedge clk_i);
    rd(6'h10, 32'h1);
    rd(6'h1c, 32'h0);
    u_eng.fire({8'h03, d, 5'h0});
    rd(6'h1c, 32'h3);
    rd(6'h18, {24'h0, d});
    rd(6'h1c, 32'h1);
    wr(6'h14, {8'h0, ~d});
    rd(6'h1c, 32'h0);
    u_eng.lines(1'b0, 1'b0, 2'h3);
    rd(6'h1c, 32'h1e00);
    u_eng.lines(1'b1, 1'b1, 2'h0);
    rd(6'h1c, 32'h0);
    ticks(64);
    @(posedge clk_i);
    debug_mode_i <= 1'b1;
    ticks(64);
    wr(6'h10, 16'h0000);
    ticks(0);
    wr(6'h00, 16'h0030);
    wr(6'h10, 16'h0001);
    ticks(0);
    @(posedge clk_i);
    debug_mode_i <= 1'b0;
    ticks(8);
    wr(6'h10, 16'h0000);
    wr(6'h00, 16'h0022);
    wr(6'h10, 16'h0001);
    ticks(16);
    wr(6'h10, 16'h0000);
    wr(6'h00, 16'h0031);
    wr(6'h10, 16'h0001);
    ticks(64);
    test_done();
  end
endmodule
